/* File: hw/tsp_i2c_slave.sv */
module tsp_i2c_slave #(
    parameter bit DUAL_PINS = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_select_pin_lo,
    input wire logic [1:0] addr_select_pin_hi,
    input wire logic thermostat_interrupt_mode,
    input wire logic alert_active,
    input wire logic alert_high,
    input wire logic [15:0] reg_rd_data,
    output logic [7:0] reg_ptr,
    output logic reg_wr,
    output logic reg_wr_lsb,
    output logic [7:0] reg_wr_data,
    output logic reg_rd,
    output logic regs_reset,
    output logic alert_clear,
    output logic [6:0] own_addr,
    output logic hs_mode
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RX,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } tsp_state_t;

    // -------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------
    // pin level decode
    function automatic logic [6:0] decode_addr(input logic [1:0] hi,
                                               input logic [1:0] lo);
        logic [6:0] a;
        a = tsp_pkg::ADR_LL;
        if (!DUAL_PINS || hi == tsp_pkg::PIN_LOW)
        begin
            if (lo == tsp_pkg::PIN_FLOAT)
                a = tsp_pkg::ADR_LF;
            else if (lo == tsp_pkg::PIN_HIGH)
                a = tsp_pkg::ADR_LH;
        end
        else if (hi == tsp_pkg::PIN_HIGH)
        begin
            if (lo == tsp_pkg::PIN_LOW)
                a = tsp_pkg::ADR_HL;
            else if (lo == tsp_pkg::PIN_FLOAT)
                a = tsp_pkg::ADR_HF;
            else
                a = tsp_pkg::ADR_HH;
        end
        else if (lo == tsp_pkg::PIN_HIGH)
            a = tsp_pkg::ADR_FH;
        else
            a = tsp_pkg::ADR_FL;
        return a;
    endfunction

    // -------------------------------------------------------------
    // Core domain: pin latch, event sink, read-word capture
    // -------------------------------------------------------------
    logic [1:0] lo_s1_q, lo_s2_q, hi_s1_q, hi_s2_q;
    logic latch_pend_q;
    logic [6:0] own_addr_q;
    logic ev_tog_q, ev_s1_q, ev_s2_q, ev_s3_q;
    logic [2:0] ev_code_q;
    logic [7:0] ev_data_q;
    logic [7:0] ptr_q;
    logic wr_q, wr_lsb_q, rd_q, rreset_q, aclr_q;
    logic [7:0] wr_data_q;
    logic rdreq_q, rq_s1_q, rq_s2_q, rdack_q;
    logic [15:0] rd_hold_q;

    wire ev_new = ev_s2_q ^ ev_s3_q;
    wire ev_ptr = ev_new && ev_code_q == tsp_pkg::EV_PTR;
    wire ev_wr = ev_new && ev_code_q == tsp_pkg::EV_WR;
    wire ev_rd = ev_new && ev_code_q == tsp_pkg::EV_RD;
    wire ev_latch = ev_new && ev_code_q == tsp_pkg::EV_LATCH;
    wire ev_reset = ev_new && ev_code_q == tsp_pkg::EV_RESET;
    wire ev_won = ev_new && ev_code_q == tsp_pkg::EV_WON;
    wire [6:0] pin_addr = decode_addr(hi_s2_q, lo_s2_q);

    always_ff @(posedge clk)
    begin
        lo_s1_q <= addr_select_pin_lo;
        lo_s2_q <= lo_s1_q;
        hi_s1_q <= addr_select_pin_hi;
        hi_s2_q <= hi_s1_q;
        ev_s1_q <= ev_tog_q;
        ev_s2_q <= ev_s1_q;
        ev_s3_q <= ev_s2_q;
        rq_s1_q <= rdreq_q;
        rq_s2_q <= rq_s1_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            latch_pend_q <= 1'b1;
            own_addr_q <= tsp_pkg::ADR_LL;
        end
        else
        begin
            latch_pend_q <= ev_latch || ev_reset;
            if (latch_pend_q)
                own_addr_q <= pin_addr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ptr_q <= tsp_pkg::PTR_RST;
            wr_q <= 1'b0;
            wr_lsb_q <= 1'b0;
            wr_data_q <= 8'h00;
            rd_q <= 1'b0;
            rreset_q <= 1'b0;
            aclr_q <= 1'b0;
            rdack_q <= 1'b0;
            rd_hold_q <= tsp_pkg::WORD_RST;
        end
        else
        begin
            // general-call reset also clears the pointer
            // otherwise it only moves on a pointer byte
            if (ev_reset)
                ptr_q <= tsp_pkg::PTR_RST;
            else if (ev_ptr)
                ptr_q <= ev_data_q;
            wr_q <= ev_wr;
            if (ev_ptr)
                wr_lsb_q <= 1'b0;
            else if (wr_q)
                wr_lsb_q <= ~wr_lsb_q;
            if (ev_wr)
                wr_data_q <= ev_data_q;
            rd_q <= ev_rd;
            rreset_q <= ev_reset;
            // alert cleared by read or won answer
            aclr_q <= ev_rd || ev_won;
            if (rq_s2_q != rdack_q)
            begin
                rd_hold_q <= reg_rd_data;
                rdack_q <= rq_s2_q;
            end
        end
    end

    // -------------------------------------------------------------
    // Link domain synchronisers
    // -------------------------------------------------------------
    logic rst_s1_q, rst_l_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic [6:0] oa_s1_q, oa_s2_q, oa_l_q;
    logic tm_s1_q, tm_l_q, al_s1_q, al_l_q, ah_s1_q, ah_l_q;
    logic ak_s1_q, ak_s2_q;

    // Core-side levels are quasi-static; the address only moves after reset, on a latch or on a general-call reset
    always_ff @(posedge link_clk)
    begin
        rst_s1_q <= rst;
        rst_l_q <= rst_s1_q;
        scl_s1_q <= scl_in;
        scl_s2_q <= scl_s1_q;
        scl_s3_q <= scl_s2_q;
        sda_s1_q <= sda_in;
        sda_s2_q <= sda_s1_q;
        sda_s3_q <= sda_s2_q;
        oa_s1_q <= own_addr_q;
        oa_s2_q <= oa_s1_q;
        // A word in flight may be torn; take it once two samples agree
        if (oa_s1_q == oa_s2_q)
            oa_l_q <= oa_s2_q;
        tm_s1_q <= thermostat_interrupt_mode;
        tm_l_q <= tm_s1_q;
        al_s1_q <= alert_active;
        al_l_q <= al_s1_q;
        ah_s1_q <= alert_high;
        ah_l_q <= ah_s1_q;
        ak_s1_q <= rdack_q;
        ak_s2_q <= ak_s1_q;
    end

    // -------------------------------------------------------------
    // Bus conditions
    // -------------------------------------------------------------
    // SDA edges with SCL high
    wire scl_hi = scl_s2_q && scl_s3_q;
    wire start_c = scl_hi && sda_s3_q && !sda_s2_q;
    wire stop_c = scl_hi && !sda_s3_q && sda_s2_q;
    wire scl_rise = scl_s2_q && !scl_s3_q;
    wire scl_fall = !scl_s2_q && scl_s3_q;

    tsp_state_t st_q;
    tsp_pkg::tsp_kind_t kind_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [15:0] word_q;
    logic word_ok_q, lsb_q, first_q, ack_tx_q, nack_q, oe_q, hs_q;
    logic armed_q;

    wire byte_done = scl_fall && bit_q == 3'h7;
    wire rw_bit = sh_q[0];
    wire own_hit = sh_q[7:1] == oa_l_q;
    wire ara_ok = sh_q == tsp_pkg::ALERT_RESP_BYTE && tm_l_q && al_l_q;
    wire gc_hit = sh_q[7:1] == tsp_pkg::GEN_CALL_ADR && !rw_bit;
    wire hs_hit = sh_q[7:3] == tsp_pkg::HS_CODE_TOP;
    wire rd_ready = ak_s2_q == rdreq_q;
    // alert answer: address, then limit bit
    wire [7:0] tx_first = (kind_q == tsp_pkg::TSP_K_ARA)
                          ? {oa_l_q, ah_l_q} : word_q[15:8];

    logic ev_tog_l_q;
    logic [2:0] ev_code_l_q;
    logic [7:0] ev_data_l_q;
    assign ev_tog_q = ev_tog_l_q;
    assign ev_code_q = ev_code_l_q;
    assign ev_data_q = ev_data_l_q;

    // -------------------------------------------------------------
    // Link state machine
    // -------------------------------------------------------------
    always_ff @(posedge link_clk)
    begin
        if (rst_l_q)
        begin
            st_q <= ST_IDLE;
            kind_q <= tsp_pkg::TSP_K_NORM;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            word_q <= tsp_pkg::WORD_RST;
            word_ok_q <= 1'b0;
            lsb_q <= 1'b0;
            first_q <= 1'b0;
            ack_tx_q <= 1'b0;
            nack_q <= 1'b0;
            oe_q <= 1'b0;
            hs_q <= 1'b0;
            armed_q <= 1'b0;
            rdreq_q <= 1'b0;
            ev_tog_l_q <= 1'b0;
            ev_code_l_q <= tsp_pkg::EV_PTR;
            ev_data_l_q <= 8'h00;
        end
        else if (stop_c)
        begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
            hs_q <= 1'b0;
        end
        else if (start_c)
        begin
            // START (or repeated START) restarts address phase
            st_q <= ST_ADDR;
            bit_q <= 3'h0;
            armed_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            if (rd_ready && !word_ok_q && st_q != ST_TX)
            begin
                word_q <= rd_hold_q;
                word_ok_q <= 1'b1;
            end
            case (st_q)
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_q <= {sh_q[6:0], sda_s2_q};
                        armed_q <= 1'b1;
                    end
                    // The SCL fall that closes a START carries no bit
                    if (scl_fall && armed_q)
                        bit_q <= bit_q + 3'h1;
                    if (byte_done && st_q == ST_ADDR)
                    begin
                        ack_tx_q <= rw_bit;
                        first_q <= 1'b1;
                        if (own_hit)
                        begin
                            oe_q <= 1'b1;
                            st_q <= ST_ACK;
                            kind_q <= tsp_pkg::TSP_K_NORM;
                            if (rw_bit)
                            begin
                                rdreq_q <= ~rdreq_q;
                                word_ok_q <= 1'b0;
                                ev_tog_l_q <= ~ev_tog_l_q;
                                ev_code_l_q <= tsp_pkg::EV_RD;
                            end
                        end
                        else if (ara_ok)
                        begin
                            oe_q <= 1'b1;
                            st_q <= ST_ACK;
                            kind_q <= tsp_pkg::TSP_K_ARA;
                        end
                        else if (gc_hit)
                        begin
                            oe_q <= 1'b1;
                            st_q <= ST_ACK;
                            kind_q <= tsp_pkg::TSP_K_GC;
                        end
                        else if (hs_hit)
                        begin
                            hs_q <= 1'b1;
                            st_q <= ST_IGNORE;
                        end
                        else
                            st_q <= ST_IGNORE;
                    end
                    else if (byte_done)
                    begin
                        oe_q <= 1'b1;
                        st_q <= ST_ACK;
                        first_q <= 1'b0;
                        ev_data_l_q <= sh_q;
                        if (kind_q == tsp_pkg::TSP_K_GC)
                        begin
                            if (first_q && sh_q == tsp_pkg::GC_CMD_LATCH)
                            begin
                                ev_tog_l_q <= ~ev_tog_l_q;
                                ev_code_l_q <= tsp_pkg::EV_LATCH;
                            end
                            else if (first_q && sh_q == tsp_pkg::GC_CMD_RESET)
                            begin
                                ev_tog_l_q <= ~ev_tog_l_q;
                                ev_code_l_q <= tsp_pkg::EV_RESET;
                            end
                        end
                        else
                        begin
                            ev_tog_l_q <= ~ev_tog_l_q;
                            ev_code_l_q <= first_q ? tsp_pkg::EV_PTR
                                                   : tsp_pkg::EV_WR;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_q <= 3'h0;
                        lsb_q <= 1'b0;
                        nack_q <= 1'b0;
                        if (ack_tx_q)
                        begin
                            sh_q <= tx_first;
                            oe_q <= ~tx_first[7];
                            st_q <= ST_TX;
                        end
                        else
                        begin
                            oe_q <= 1'b0;
                            st_q <= ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_rise && !oe_q && !sda_s2_q)
                        st_q <= ST_IGNORE;
                    else if (byte_done)
                    begin
                        oe_q <= 1'b0;
                        st_q <= ST_TX_ACK;
                    end
                    else if (scl_fall)
                    begin
                        bit_q <= bit_q + 3'h1;
                        sh_q <= {sh_q[6:0], 1'b0};
                        oe_q <= ~sh_q[6];
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        nack_q <= sda_s2_q;
                    if (scl_fall)
                    begin
                        bit_q <= 3'h0;
                        if (kind_q == tsp_pkg::TSP_K_ARA)
                        begin
                            // won: clear alert at end of command
                            ev_tog_l_q <= ~ev_tog_l_q;
                            ev_code_l_q <= tsp_pkg::EV_WON;
                            st_q <= ST_IGNORE;
                        end
                        else if (nack_q)
                            st_q <= ST_IGNORE;
                        else
                        begin
                            sh_q <= lsb_q ? word_q[15:8] : word_q[7:0];
                            oe_q <= lsb_q ? ~word_q[15] : ~word_q[7];
                            lsb_q <= ~lsb_q;
                            st_q <= ST_TX;
                        end
                    end
                end
                ST_IGNORE:
                    oe_q <= 1'b0;
                ST_IDLE:
                    oe_q <= 1'b0;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    // the clock line is never driven; SDA is open drain
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign hs_mode = hs_q;
    assign reg_ptr = ptr_q;
    assign reg_wr = wr_q;
    assign reg_wr_lsb = wr_lsb_q;
    assign reg_wr_data = wr_data_q;
    assign reg_rd = rd_q;
    assign regs_reset = rreset_q;
    assign alert_clear = aclr_q;
    assign own_addr = own_addr_q;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    property p_start;
        @(posedge link_clk) disable iff (rst_l_q)
        start_c && !stop_c |=> st_q == ST_ADDR && bit_q == 3'h0;
    endproperty
    a_start: assert property (p_start) else $error("start missed");

    property p_stop;
        @(posedge link_clk) disable iff (rst_l_q)
        stop_c |=> st_q == ST_IDLE && !oe_q && !hs_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop missed");

    property p_drive_low;
        @(posedge link_clk) disable iff (rst_l_q)
        $rose(oe_q) |-> !scl_s2_q;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda in high");

    property p_own_ack;
        @(posedge link_clk) disable iff (rst_l_q)
        st_q == ST_ADDR && byte_done && own_hit && !start_c && !stop_c
        |=> oe_q && st_q == ST_ACK;
    endproperty
    a_own_ack: assert property (p_own_ack) else $error("no ack");

    property p_hs_enter;
        @(posedge link_clk) disable iff (rst_l_q)
        st_q == ST_ADDR && byte_done && hs_hit && !own_hit && !ara_ok
        && !start_c && !stop_c |=> hs_q && !oe_q;
    endproperty
    a_hs_enter: assert property (p_hs_enter) else $error("hs entry");

    property p_hs_stay;
        @(posedge link_clk) disable iff (rst_l_q)
        hs_q && !stop_c |=> hs_q;
    endproperty
    a_hs_stay: assert property (p_hs_stay) else $error("hs dropped");

    property p_ignore;
        @(posedge link_clk) disable iff (rst_l_q)
        st_q == ST_IGNORE |=> !oe_q;
    endproperty
    a_ignore: assert property (p_ignore) else $error("sda held");

    property p_lost;
        @(posedge link_clk) disable iff (rst_l_q)
        st_q == ST_TX && scl_rise && !oe_q && !sda_s2_q && !stop_c
        && !start_c |=> st_q == ST_IGNORE ##1 !oe_q;
    endproperty
    a_lost: assert property (p_lost) else $error("arb loss");

    property p_ptr_keep;
        @(posedge clk) disable iff (rst)
        !ev_ptr && !ev_reset |=> $stable(ptr_q);
    endproperty
    a_ptr_keep: assert property (p_ptr_keep) else $error("ptr moved");

    property p_relatch;
        @(posedge clk) disable iff (rst)
        (ev_latch || ev_reset) ##1 $stable(pin_addr)
        |=> own_addr_q == $past(pin_addr);
    endproperty
    a_relatch: assert property (p_relatch) else $error("no relatch");

    property p_gc_reset;
        @(posedge clk) disable iff (rst)
        ev_reset |=> regs_reset ##1 !regs_reset;
    endproperty
    a_gc_reset: assert property (p_gc_reset) else $error("no reset");

endmodule // tsp_i2c_slave

/* File: hw/tsp_pkg.sv */
package tsp_pkg;

    // -------------------------------------------------------------
    // Slave addresses by address-select pin level
    // -------------------------------------------------------------
    localparam logic [6:0] ADR_LL = 7'h48;
    localparam logic [6:0] ADR_LF = 7'h49;
    localparam logic [6:0] ADR_LH = 7'h4a;
    localparam logic [6:0] ADR_HL = 7'h4c;
    localparam logic [6:0] ADR_HF = 7'h4d;
    localparam logic [6:0] ADR_HH = 7'h4e;
    localparam logic [6:0] ADR_FL = 7'h4b;
    localparam logic [6:0] ADR_FH = 7'h4f;

    // Pin level codes on the address-select inputs
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_FLOAT = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;

    // -------------------------------------------------------------
    // Special bus addresses and commands
    // -------------------------------------------------------------
    localparam logic [7:0] ALERT_RESP_BYTE = 8'h19;
    localparam logic [6:0] GEN_CALL_ADR = 7'h00;
    localparam logic [7:0] GC_CMD_LATCH = 8'h04;
    localparam logic [7:0] GC_CMD_RESET = 8'h06;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;

    // Events passed from the link domain to the core domain
    localparam logic [2:0] EV_PTR = 3'h0;
    localparam logic [2:0] EV_WR = 3'h1;
    localparam logic [2:0] EV_RD = 3'h2;
    localparam logic [2:0] EV_LATCH = 3'h3;
    localparam logic [2:0] EV_RESET = 3'h4;
    localparam logic [2:0] EV_WON = 3'h5;

    // Reset values
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef enum logic [1:0] {
        TSP_K_NORM,
        TSP_K_GC,
        TSP_K_ARA
    } tsp_kind_t;

endpackage

/* File: tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin n_errors++; \
$display("unexpected %s exp %h got %h", n, e, s); end end
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic scl_in, sda_m, sda_out, sda_oe, reg_wr, reg_rd, regs_reset;
    logic alert_clear, hs_mode, reg_wr_lsb;
    logic [7:0] reg_ptr, reg_wr_data, p, d;
    logic [6:0] own_addr;
    logic [1:0] addr_select_pin_lo = 2'h0, addr_select_pin_hi = 2'h0;
    logic thermostat_interrupt_mode = 1'b0, alert_active = 1'b0;
    logic alert_high = 1'b1;
    logic [15:0] reg_rd_data = 16'h0000;
    logic [8:0] r, w;
    logic [8:0] exq[$];
    logic [6:0] tbl[9] = '{7'h48, 7'h49, 7'h4a, 7'h4b, 7'h4b, 7'h4f,
        7'h4c, 7'h4d, 7'h4e};
    int n_errors = 0, checks = 0, cyc = 0, n_clr = 0, n_rst = 0, n_rd = 0;
    // Open drain with pull-up: released line reads high
    wire sda_in = sda_m & (sda_oe ? sda_out : 1'b1);
    initial forever #5 clk = ~clk;
    initial
    begin
        #3;
        forever #62.5 link_clk = ~link_clk;
    end
    tsp_i2c_slave dut_u (.clk, .rst, .link_clk, .scl_in, .sda_in, .sda_out,
        .sda_oe, .addr_select_pin_lo, .addr_select_pin_hi, .alert_high,
        .thermostat_interrupt_mode, .alert_active, .reg_rd_data, .reg_ptr,
        .reg_wr, .reg_wr_lsb, .reg_wr_data, .reg_rd, .regs_reset,
        .alert_clear, .own_addr, .hs_mode);
    tsp_bus_master m_u (.link_clk, .sda_in, .scl(scl_in), .sda_o(sda_m));
    always @(posedge clk)
    begin
        cyc++;
        n_clr += (alert_clear === 1'b1);
        n_rst += (regs_reset === 1'b1);
        n_rd += (reg_rd === 1'b1);
        if (reg_wr === 1'b1)
        begin
            w = exq.pop_front();
            `CHK("wr_data", w, {reg_wr_lsb, reg_wr_data})
        end
        if (cyc == 70000)
        begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic sb(input logic [7:0] b, input logic a, input string n);
        m_u.xfer({b, 1'b1}, r);
        `CHK(n, ~a, r[0])
    endtask
    task automatic rw(input logic k, input logic [7:0] e, input string n);
        m_u.xfer({8'hff, k}, r);
        `CHK(n, e, r[8:1])
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h9756));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (60) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
            addr_select_pin_hi <= 2'(i / 3);
            addr_select_pin_lo <= 2'(i % 3);
            m_u.start();
            sb(8'h00, 1'b1, "gc_ack");
            sb(tsp_pkg::GC_CMD_LATCH, 1'b1, "gc_latch");
            m_u.stop();
            repeat (60) @(posedge clk);
            `CHK("own_addr", tbl[i], own_addr)
        end
        $display("test address done");
        p = 8'($urandom_range(3));
        d = 8'($urandom);
        reg_rd_data <= 16'($urandom);
        exq.push_back({1'b0, d});
        exq.push_back({1'b1, ~d});
        m_u.start();
        sb(8'h9c, 1'b1, "adr_w");
        sb(p, 1'b1, "ptr");
        sb(d, 1'b1, "d0");
        sb(~d, 1'b1, "d1");
        m_u.stop();
        `CHK("ptr", p, reg_ptr)
        m_u.start();
        sb(8'h9c, 1'b1, "adr_w");
        sb(p ^ 8'h01, 1'b1, "ptr2");
        for (int i = 0; i < 2; i++)
        begin
            m_u.start();
            sb(8'h9d, 1'b1, "adr_r");
            rw(1'b0, reg_rd_data[15:8], "msb");
            rw(1'b1, reg_rd_data[7:0], "lsb");
        end
        m_u.stop();
        `CHK("ptr", p ^ 8'h01, reg_ptr)
        repeat (60) @(posedge clk);
        `CHK("clr", 2, n_clr)
        `CHK("rd", 2, n_rd)
        $display("test data done");
        m_u.start();
        sb(8'h91, 1'b0, "other");
        rw(1'b1, 8'hff, "idle");
        m_u.start();
        sb(8'h09, 1'b0, "hs_code");
        `CHK("hs", 1'b1, hs_mode)
        m_u.start();
        sb(8'h9c, 1'b1, "hs_adr");
        `CHK("hs", 1'b1, hs_mode)
        m_u.stop();
        repeat (60) @(posedge clk);
        `CHK("hs", 1'b0, hs_mode)
        $display("test mode done");
        thermostat_interrupt_mode <= 1'b1;
        alert_active <= 1'b1;
        // A lower-addressed responder wins: we must drop out
        m_u.start();
        sb(tsp_pkg::ALERT_RESP_BYTE, 1'b1, "ara_lose");
        m_u.xfer({8'h00, 1'b1}, r);
        `CHK("ara_lost", 8'h00, r[8:1])
        m_u.start();
        sb(tsp_pkg::ALERT_RESP_BYTE, 1'b1, "ara");
        rw(1'b1, {7'h4e, 1'b1}, "ara_adr");
        m_u.stop();
        repeat (60) @(posedge clk);
        `CHK("clr", 3, n_clr)
        thermostat_interrupt_mode <= 1'b0;
        m_u.start();
        sb(tsp_pkg::ALERT_RESP_BYTE, 1'b0, "ara_cmp");
        m_u.start();
        sb(8'h00, 1'b1, "gc_ack");
        sb(tsp_pkg::GC_CMD_RESET, 1'b1, "gc_rst");
        m_u.stop();
        repeat (60) @(posedge clk);
        `CHK("rst", 1, n_rst)
        `CHK("ptr", tsp_pkg::PTR_RST, reg_ptr)
        $display("test alert done");
        results();
    end
endmodule // testbench

/* File: tb/tsp_bus_master.sv */
module tsp_bus_master
(
    input wire logic link_clk,
    input wire logic sda_in,
    output logic scl = 1'b1,
    output logic sda_o = 1'b1
);
    timeunit 1ns;
    timeprecision 100ps;

    task automatic hold(input int n);
        repeat (n) @(posedge link_clk);
    endtask

    task automatic start();
        sda_o <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(5);
        sda_o <= 1'b0;
        hold(5);
        scl <= 1'b0;
        hold(2);
    endtask

    task automatic stop();
        sda_o <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(5);
        sda_o <= 1'b1;
        hold(5);
    endtask

    // data moves only while clock low
    // Nine bits: byte then ack slot, sampled late in the high phase
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            sda_o <= d[i];
            hold(2);
            scl <= 1'b1;
            hold(3);
            r[i] = sda_in;
            hold(1);
            scl <= 1'b0;
            hold(2);
        end
    endtask
endmodule // tsp_bus_master
